// ### rtl/bmc_cc_line_codec_cfg.svh
// Contract
// R1: Toggle at every bit start; ones toggle again mid-bit; decoder uses same rule.
// R2: Keep coded stream DC balanced, disparity never beyond half a bit.
// R3: Preamble starts by driving the line low before the first transition.
// R4: Receiver locks and decodes even if the very first edge is lost; the code then loses the first bit and decodes from the second.
// R5: After final end-of-packet bit, emit one closing transition before release.
// R6: Transmit and receive only on the pin picked by cable orientation.
// R7: Drive the selected pin through a tri-state driver enabled by transmit logic.
// R8: Hold driver in high impedance whenever not transmitting.
// R9: Time bits and half-bits, and sample receive, from a clock-counted tick; receive instead samples every clock and times edges with rx_cnt.
`ifndef BMC_CC_LINE_CODEC_CFG_SVH
`define BMC_CC_LINE_CODEC_CFG_SVH

`define BMC_CLK_PERIOD_NS   8
`define BMC_HALF_BIT_NS     1667
`define BMC_HALF_BIT_CYCLES (`BMC_HALF_BIT_NS / `BMC_CLK_PERIOD_NS)
`define BMC_CNT_W           10
`define BMC_RX_TIMEOUT_HALVES 4
`define BMC_LINE_RST        1'b0

`endif

// ### rtl/bmc_cc_line_codec_pkg.sv
`include "bmc_cc_line_codec_cfg.svh"

package bmc_cc_line_codec_pkg;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_LEAD,
        TX_FIRST,
        TX_SECOND,
        TX_CLOSE
    } tx_state_e;

    typedef logic [`BMC_CNT_W-1:0] cnt_t;

    typedef struct packed {
        cnt_t cnt;
        logic tick;
    } timer_s;

    typedef struct packed {
        tx_state_e state;
        logic      level;
        logic      oe;
        logic      bit_val;
        logic      last;
        logic      sel_b;
        logic      take;
        logic      busy;
        logic      a_lvl;
        logic      a_oe;
        logic      b_lvl;
        logic      b_oe;
        cnt_t      rx_cnt;
        logic      rx_prev;
        logic      rx_active;
        logic      rx_half;
        logic      rx_valid;
        logic      rx_bit;
    } codec_s;

endpackage

// ### rtl/bmc_half_bit_timer.sv
`timescale 1ns/1ps
`include "bmc_cc_line_codec_cfg.svh"

module bmc_half_bit_timer #(
    parameter int unsigned HALF_CYCLES = `BMC_HALF_BIT_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic ce_i,
    input  wire logic restart_i,
    output logic      tick_o
);
    localparam int CW = `BMC_CNT_W;
    localparam bmc_cc_line_codec_pkg::cnt_t LAST = CW'(HALF_CYCLES - 1);

    bmc_cc_line_codec_pkg::timer_s s_ff;
    bmc_cc_line_codec_pkg::timer_s nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.tick = 1'b0;
        if (restart_i) begin
            nxt_s.cnt = '0;
        end else if (s_ff.cnt == LAST) begin
            nxt_s.cnt  = '0;
            nxt_s.tick = 1'b1; // R9
        end else begin
            nxt_s.cnt = s_ff.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_ff <= '0;
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    assign tick_o = s_ff.tick;
endmodule

// ### rtl/bmc_cc_line_codec.sv
`timescale 1ns/1ps
`include "bmc_cc_line_codec_cfg.svh"

module bmc_cc_line_codec #(
    parameter int unsigned HALF_CYCLES = `BMC_HALF_BIT_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic ce_i,
    input  wire logic orient_b_i,
    input  wire logic tx_valid_i,
    input  wire logic tx_bit_i,
    input  wire logic tx_last_i,
    output logic      tx_take_o,
    output logic      tx_busy_o,
    input  wire logic cc_line_a_i,
    output logic      cc_line_a_o,
    output logic      cc_line_a_oe_o,
    input  wire logic cc_line_b_i,
    output logic      cc_line_b_o,
    output logic      cc_line_b_oe_o,
    output logic      rx_valid_o,
    output logic      rx_bit_o,
    output logic      rx_active_o
);
    localparam int CW = `BMC_CNT_W;
    // Below one and a half halves counts as a half-bit interval
    localparam bmc_cc_line_codec_pkg::cnt_t RX_SHORT_LIM =
        CW'(HALF_CYCLES + HALF_CYCLES / 2);
    localparam bmc_cc_line_codec_pkg::cnt_t RX_TIMEOUT =
        CW'(HALF_CYCLES * `BMC_RX_TIMEOUT_HALVES);

    bmc_cc_line_codec_pkg::codec_s s_ff;
    bmc_cc_line_codec_pkg::codec_s nxt_s;

    logic tick;
    logic restart;
    logic rx_line;

    assign restart = (s_ff.state == bmc_cc_line_codec_pkg::TX_IDLE);

    bmc_half_bit_timer #(
        .HALF_CYCLES (HALF_CYCLES)
    ) u_timer (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .ce_i      (ce_i),
        .restart_i (restart),
        .tick_o    (tick)
    );

    // Receive follows the live orientation while idle, the latched one while sending
    assign rx_line = (s_ff.busy ? s_ff.sel_b : orient_b_i) ? cc_line_b_i : cc_line_a_i; // R6

    always_comb begin
        nxt_s = s_ff;
        nxt_s.take = 1'b0;
        nxt_s.rx_valid = 1'b0;

        case (s_ff.state)
            bmc_cc_line_codec_pkg::TX_IDLE: begin
                nxt_s.oe    = 1'b0; // R8
                nxt_s.level = `BMC_LINE_RST;
                if (tx_valid_i) begin
                    nxt_s.sel_b = orient_b_i;
                    nxt_s.oe    = 1'b1; // R7
                    nxt_s.level = 1'b0; // R3
                    nxt_s.state = bmc_cc_line_codec_pkg::TX_LEAD;
                end
            end
            bmc_cc_line_codec_pkg::TX_LEAD,
            bmc_cc_line_codec_pkg::TX_SECOND: begin
                if (tick) begin
                    if (s_ff.state == bmc_cc_line_codec_pkg::TX_SECOND && s_ff.last) begin
                        nxt_s.level = ~s_ff.level; // R5
                        nxt_s.state = bmc_cc_line_codec_pkg::TX_CLOSE;
                    end else if (tx_valid_i) begin
                        nxt_s.level   = ~s_ff.level; // R1
                        nxt_s.bit_val = tx_bit_i;
                        nxt_s.last    = tx_last_i;
                        nxt_s.take    = 1'b1;
                        nxt_s.state   = bmc_cc_line_codec_pkg::TX_FIRST;
                    end else begin
                        // Underrun still ends cleanly with the closing edge
                        nxt_s.level = ~s_ff.level; // R5
                        nxt_s.state = bmc_cc_line_codec_pkg::TX_CLOSE;
                    end
                end
            end
            bmc_cc_line_codec_pkg::TX_FIRST: begin
                if (tick) begin
                    // Equal half cells keep the disparity within half a bit
                    if (s_ff.bit_val) begin
                        nxt_s.level = ~s_ff.level; // R1 R2
                    end
                    nxt_s.state = bmc_cc_line_codec_pkg::TX_SECOND;
                end
            end
            bmc_cc_line_codec_pkg::TX_CLOSE: begin
                if (tick) begin
                    nxt_s.oe    = 1'b0; // R8
                    nxt_s.level = `BMC_LINE_RST;
                    nxt_s.last  = 1'b0;
                    nxt_s.state = bmc_cc_line_codec_pkg::TX_IDLE;
                end
            end
            default: begin
                nxt_s.oe    = 1'b0;
                nxt_s.state = bmc_cc_line_codec_pkg::TX_IDLE;
            end
        endcase

        nxt_s.busy  = (nxt_s.state != bmc_cc_line_codec_pkg::TX_IDLE);
        nxt_s.a_lvl = nxt_s.level & ~nxt_s.sel_b;
        nxt_s.a_oe  = nxt_s.oe & ~nxt_s.sel_b; // R6 R7
        nxt_s.b_lvl = nxt_s.level & nxt_s.sel_b;
        nxt_s.b_oe  = nxt_s.oe & nxt_s.sel_b; // R6 R7

        // Receive side; own transmission is not echoed back
        nxt_s.rx_prev = rx_line;
        if (s_ff.oe) begin
            nxt_s.rx_active = 1'b0;
            nxt_s.rx_half   = 1'b0;
            nxt_s.rx_cnt    = '0;
        end else if (rx_line != s_ff.rx_prev) begin
            nxt_s.rx_cnt = '0;
            if (!s_ff.rx_active) begin
                // Any edge may be the first; a lost lead edge costs the first bit
                nxt_s.rx_active = 1'b1; // R4
                nxt_s.rx_half   = 1'b0;
            end else if (s_ff.rx_cnt < RX_SHORT_LIM) begin // R9
                if (s_ff.rx_half) begin
                    nxt_s.rx_valid = 1'b1; // R1
                    nxt_s.rx_bit   = 1'b1;
                    nxt_s.rx_half  = 1'b0;
                end else begin
                    nxt_s.rx_half = 1'b1;
                end
            end else begin
                // A stray half before a full cell is dropped to realign
                nxt_s.rx_valid = 1'b1; // R1 R4
                nxt_s.rx_bit   = 1'b0;
                nxt_s.rx_half  = 1'b0;
            end
        end else if (s_ff.rx_active) begin
            if (s_ff.rx_cnt >= RX_TIMEOUT) begin
                nxt_s.rx_active = 1'b0;
                nxt_s.rx_half   = 1'b0;
            end else begin
                nxt_s.rx_cnt = s_ff.rx_cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_ff <= '0;
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    assign tx_take_o      = s_ff.take;
    assign tx_busy_o      = s_ff.busy;
    assign cc_line_a_o    = s_ff.a_lvl;
    assign cc_line_a_oe_o = s_ff.a_oe;
    assign cc_line_b_o    = s_ff.b_lvl;
    assign cc_line_b_oe_o = s_ff.b_oe;
    assign rx_valid_o     = s_ff.rx_valid;
    assign rx_bit_o       = s_ff.rx_bit;
    assign rx_active_o    = s_ff.rx_active;
endmodule

// ### testbench/bmc_codec_checker.sv
`timescale 1ns/1ps
`include "bmc_cc_line_codec_cfg.svh"
module bmc_codec_checker #(
    parameter int unsigned HALF_CYCLES = `BMC_HALF_BIT_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic ce_i,
    input  wire logic orient_b_i,
    input  wire logic tx_valid_i,
    input  wire logic tx_take_o,
    input  wire logic tx_busy_o,
    input  wire logic cc_line_a_o,
    input  wire logic cc_line_a_oe_o,
    input  wire logic cc_line_b_o,
    input  wire logic cc_line_b_oe_o,
    input  wire logic rx_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    wire logic   oe  = cc_line_a_oe_o | cc_line_b_oe_o;
    wire logic   lvl = cc_line_a_o | cc_line_b_o;
    logic        lvl_ff;
    logic        seen_ff;
    int unsigned gap_ff;
    wire logic   flip = oe && (lvl != lvl_ff);
    // Gap counts cycles since the last driven edge; lead-in edge excluded
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lvl_ff  <= 1'b0;
            seen_ff <= 1'b0;
            gap_ff  <= 0;
        end else begin
            lvl_ff  <= lvl;
            seen_ff <= oe && (seen_ff || flip);
            gap_ff  <= flip ? 0 : gap_ff + 1;
        end
    end
    one_pin_only_a: assert property (!(cc_line_a_oe_o && cc_line_b_oe_o)) else $error("both pins driven");
    pin_follows_a: assert property ($rose(oe) |-> cc_line_b_oe_o == $past(orient_b_i)) else $error("wrong pin driven");
    idle_hiz_a: assert property (!tx_busy_o |-> !oe) else $error("driver on while idle");
    lead_low_a: assert property ($rose(oe) |-> !lvl) else $error("frame not led low");
    start_drive_a: assert property (tx_valid_i && ce_i && !tx_busy_o |=> tx_busy_o && oe) else $error("frame start missed");
    edge_spacing_a: assert property (flip && seen_ff |-> gap_ff == HALF_CYCLES - 1 || gap_ff == 2 * HALF_CYCLES - 1) else $error("edge off the half-bit grid");
    take_spacing_a: assert property (tx_take_o |=> !tx_take_o [*7]) else $error("bits taken too close");
    rx_muted_a: assert property (rx_valid_o |-> !oe && !tx_busy_o) else $error("receive during transmit");
    rx_pulse_a: assert property (rx_valid_o |=> !rx_valid_o) else $error("receive pulse too long");
endmodule
bind bmc_cc_line_codec bmc_codec_checker #(.HALF_CYCLES(HALF_CYCLES)) i_bmc_codec_checker (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .orient_b_i(orient_b_i),
    .tx_valid_i(tx_valid_i), .tx_take_o(tx_take_o), .tx_busy_o(tx_busy_o),
    .cc_line_a_o(cc_line_a_o), .cc_line_a_oe_o(cc_line_a_oe_o), .cc_line_b_o(cc_line_b_o),
    .cc_line_b_oe_o(cc_line_b_oe_o), .rx_valid_o(rx_valid_o));

// ### testbench/bmc_far_end.sv
`timescale 1ns/1ps
module bmc_far_end #(
    parameter int H = 8
) (
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      lvl_o,
    output logic      oe_o
);
    logic got_q[$];
    int   cnt = 0;
    int   t0 = 0;
    logic act = 0;
    logic half = 0;
    logic prev = 0;
    initial begin
        lvl_o = 1'b0;
        oe_o  = 1'b0;
    end
    // First edge only starts timing, so a lost lead edge costs the first bit
    always @(posedge clk_i) begin
        cnt++;
        if (!oe_o && line_i !== prev) begin
            if (act && cnt - t0 < H + H / 2) begin
                if (half) got_q.push_back(1'b1);
                half = !half;
            end else if (act) begin
                got_q.push_back(1'b0);
                half = 1'b0;
            end
            act = 1'b1;
            t0 = cnt;
        end else if (cnt - t0 > 4 * H) begin
            act = 1'b0;
            half = 1'b0;
        end
        prev = line_i;
    end
    task automatic send(input logic [15:0] b, input int n, input bit drop);
        oe_o  <= 1'b1;
        lvl_o <= 1'b0;
        repeat (H) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            if (!(drop && i == 0)) lvl_o <= !lvl_o;
            repeat (H) @(posedge clk_i);
            if (b[i]) lvl_o <= !lvl_o;
            repeat (H) @(posedge clk_i);
        end
        lvl_o <= !lvl_o;
        repeat (H) @(posedge clk_i);
        oe_o  <= 1'b0;
        lvl_o <= 1'b0;
    endtask
endmodule

// ### testbench/bmc_cc_line_codec_bench.sv
`timescale 1ns/1ps
module bmc_cc_line_codec_bench;
    localparam int H = 8;
    logic clk_i = 0, arst_n_i = 0, orient_b_i = 0, tx_valid_i = 0, tx_bit_i = 0, tx_last_i = 0;
    logic ce_i = 1;
    logic a_o, a_oe, b_o, b_oe, take, busy, rxv, rxb, p_lvl, p_oe, rx_act;
    int   n_mismatch = 0;
    int   checks_done = 0;
    logic rx_q[$];
    // Undriven wire settles to the attach bias level
    wire logic wire_a = a_oe ? a_o : (!orient_b_i && p_oe) ? p_lvl : 1'b0;
    wire logic wire_b = b_oe ? b_o : (orient_b_i && p_oe) ? p_lvl : 1'b0;
    always #4 clk_i = !clk_i;
    bmc_cc_line_codec #(.HALF_CYCLES(H)) i_bmc_cc_line_codec (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .ce_i(ce_i), .orient_b_i(orient_b_i), .tx_valid_i(tx_valid_i), .tx_bit_i(tx_bit_i),
        .tx_last_i(tx_last_i), .tx_take_o(take), .tx_busy_o(busy), .cc_line_a_i(wire_a),
        .cc_line_a_o(a_o), .cc_line_a_oe_o(a_oe), .cc_line_b_i(wire_b), .cc_line_b_o(b_o),
        .cc_line_b_oe_o(b_oe), .rx_valid_o(rxv), .rx_bit_o(rxb), .rx_active_o(rx_act));
    bmc_far_end #(.H(H)) i_bmc_far_end (.clk_i(clk_i), .line_i(orient_b_i ? wire_b : wire_a),
        .lvl_o(p_lvl), .oe_o(p_oe));
    always @(posedge clk_i) if (rxv === 1'b1) rx_q.push_back(rxb);
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Even edge count keeps the release from adding a stray edge
    function automatic logic [15:0] frame(input int n);
        logic [15:0] b;
        b = 16'($urandom) & ((16'h1 << n) - 16'h1);
        b[n-1] = b[n-1] ^ ((n + $countones(b) + 1) % 2);
        return b;
    endfunction
    function automatic logic [15:0] packq(input logic q[$]);
        logic [15:0] v = '0;
        foreach (q[i]) v[i] = q[i];
        return v;
    endfunction
    task automatic idle_wait;
        int g = 0;
        while (busy !== 1'b0 && g < 64 * H) begin @(negedge clk_i); g++; end
        if (g == 64 * H) begin n_mismatch++; wrap_up(); end
        repeat (6 * H) @(negedge clk_i);
    endtask
    task automatic tx_frame(input logic [15:0] b, input int n, input bit under);
        int g;
        i_bmc_far_end.got_q.delete();
        orient_b_i = 1'($urandom_range(0, 1));
        tx_valid_i = 1'b1;
        tx_bit_i = b[0];
        // Underrun must close the frame at the same boundary as a flagged last bit
        tx_last_i = (n == 1) && !under;
        for (int i = 0; i < n; i++) begin
            g = 0;
            while (take !== 1'b1 && g < 8 * H) begin @(negedge clk_i); g++; end
            if (g == 8 * H) begin n_mismatch++; wrap_up(); end
            tx_bit_i = b[(i + 1) % 16];
            tx_last_i = (i + 2 == n) && !under;
            if (i + 1 == n) tx_valid_i = 1'b0;
            @(negedge clk_i);
        end
        idle_wait();
        chk("tx count", 16'(i_bmc_far_end.got_q.size()), 16'(n));
        chk("tx bits", packq(i_bmc_far_end.got_q), b);
        chk("tx no echo", 16'(rx_act), 16'h0);
    endtask
    task automatic rx_frame(input logic [15:0] b, input int n, input bit drop);
        rx_q.delete();
        orient_b_i = 1'($urandom_range(0, 1));
        i_bmc_far_end.send(b, n, drop);
        @(negedge clk_i);
        chk("rx active", 16'(rx_act), 16'h1);
        idle_wait();
        chk("rx timeout", 16'(rx_act), 16'h0);
        chk("rx count", 16'(rx_q.size()), 16'(n - drop));
        chk("rx bits", packq(rx_q), b >> drop);
    endtask
    initial begin
        int n;
        void'($urandom(79361));
        repeat (20) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        // Frozen clock enable must not let a request start a frame
        ce_i = 1'b0;
        tx_valid_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk("frozen drive", 16'({a_oe, b_oe, busy}), 16'h0);
        ce_i = 1'b1;
        tx_valid_i = 1'b0;
        @(negedge clk_i);
        tx_frame(16'h0000, 1, 1'b0);
        for (int k = 0; k < 10; k++) begin
            n = $urandom_range(2, 12);
            if (k % 2 == 0) tx_frame(frame(n), n, (k % 4 == 2));
            else rx_frame(frame(n), n, 1'b0);
        end
        // Reset in mid-frame must release the pin at once
        orient_b_i = 1'b1;
        tx_valid_i = 1'b1;
        tx_bit_i = 1'b1;
        tx_last_i = 1'b0;
        repeat (3 * H) @(negedge clk_i);
        arst_n_i = 1'b0;
        @(negedge clk_i);
        chk("reset drive", 16'({a_oe, b_oe, busy, take}), 16'h0);
        tx_valid_i = 1'b0;
        arst_n_i = 1'b1;
        idle_wait();
        rx_frame(16'h0aaa, 12, 1'b1);
        wrap_up();
    end
endmodule
